// ==== logic/cih_top.sv ====
/*
 control input handler: soft init, self test, maskable interrupt with
 acknowledge cycles, inquire invalidate and cache enable handling.
 assumes all inputs synchronous to i_ref_clk; the core signals
 instruction boundaries and bus cycle completion.
*/
// What this block does
// - soft init restarts only in run state, keeps caches and buffers
// - init high at reset fall runs self test
// - enabled interrupt gives two locked acknowledges
// - interrupt taken only at instruction boundary
// - inquire hit line shared or invalid
// - invalidate sampled with strobe clock
// - cache enable decides cycle length
// - cacheable cycle plus enable gives burst fill
// - pin zero maskable or local line zero
// - pin one nonmaskable or local line one
`timescale 1ns/10ps
`include "cih_defs.svh"
module cih_top
    import cih_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // control pins
    input wire logic i_soft_init,
    input wire logic i_pin_irq0,
    input wire logic i_pin_irq1,
    input wire logic i_lic_enable,
    input wire logic i_inquire_invalidate_in,
    input wire logic i_external_addr_strobe_n,
    input wire logic i_inquire_hit,
    input wire logic i_cache_enable_in_n,
    // core side
    input wire logic i_if_flag,
    input wire logic i_instr_done,
    input wire cih_cycle_s i_cycle,
    input wire logic i_bus_ready,
    // outputs
    output logic o_core_reset,
    output logic o_bist_active,
    output logic o_running,
    output logic o_inta_cycle,
    output logic o_bus_lock,
    output logic o_vector_take,
    output logic o_nmi,
    output logic o_local_irq_line_zero,
    output logic o_local_irq_line_one,
    output logic o_line_update,
    output cih_line_e o_line_state,
    output logic o_burst_fill,
    output logic [2:0] o_xfer_count
);
    cih_state_e state_reg;
    cih_state_e state_next;
    cih_irq_s irq;
    logic rst_seen_reg;
    logic init_prev_reg;
    logic [7:0] bist_cnt_reg;
    logic [2:0] ack_cnt_reg;
    logic [1:0] ack_num_reg;
    logic inq_pend_reg;
    logic inv_reg;
    logic init_pulse;
    logic take_irq;

    cih_irq_router u_router (
        .i_pin_irq0(i_pin_irq0),
        .i_pin_irq1(i_pin_irq1),
        .i_lic_enable(i_lic_enable),
        .o_irq(irq)
    );

    // hardware reset is the only power-up path
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            rst_seen_reg <= 1'b1;
        end else begin
            rst_seen_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            init_prev_reg <= 1'b0;
        end else begin
            init_prev_reg <= i_soft_init;
        end
    end

    // rising edge only, so a held init does not loop the restart
    assign init_pulse = i_soft_init & ~init_prev_reg;
    assign take_irq = irq.maskable_irq_in & i_if_flag & i_instr_done;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CIH_ST_RESET: begin
                // init level at reset release picks self test
                if (i_soft_init) begin
                    state_next = CIH_ST_BIST;
                end else begin
                    state_next = CIH_ST_RUN;
                end
            end
            CIH_ST_BIST: begin
                if (bist_cnt_reg == `CIH_BIST_LEN) begin
                    state_next = CIH_ST_RUN;
                end
            end
            CIH_ST_RUN: begin
                if (init_pulse) begin
                    state_next = CIH_ST_RUN;
                end else if (take_irq) begin
                    state_next = CIH_ST_ACK1;
                end
            end
            CIH_ST_ACK1: begin
                if (ack_cnt_reg == `CIH_ACK_LEN) begin
                    state_next = CIH_ST_ACK2;
                end
            end
            CIH_ST_ACK2: begin
                if (ack_cnt_reg == `CIH_ACK_LEN) begin
                    state_next = CIH_ST_VECTOR;
                end
            end
            CIH_ST_VECTOR: begin
                state_next = CIH_ST_RUN;
            end
            default: begin
                state_next = CIH_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= CIH_ST_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // self test length counter
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            bist_cnt_reg <= 8'h00;
        end else if (state_reg == CIH_ST_BIST) begin
            bist_cnt_reg <= bist_cnt_reg + 8'h01;
        end else begin
            bist_cnt_reg <= 8'h00;
        end
    end

    // two acknowledge cycles, each ack length plus one clocks
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_cnt_reg <= 3'h0;
            ack_num_reg <= 2'h0;
        end else if (state_reg == CIH_ST_ACK1 ||
                     state_reg == CIH_ST_ACK2) begin
            if (ack_cnt_reg == `CIH_ACK_LEN) begin
                ack_cnt_reg <= 3'h0;
                ack_num_reg <= ack_num_reg + 2'h1;
            end else begin
                ack_cnt_reg <= ack_cnt_reg + 3'h1;
            end
        end else begin
            ack_cnt_reg <= 3'h0;
            ack_num_reg <= 2'h0;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_inta_cycle <= 1'b0;
            o_bus_lock <= 1'b0;
            o_vector_take <= 1'b0;
        end else begin
            o_inta_cycle <= (state_next == CIH_ST_ACK1) ||
                            (state_next == CIH_ST_ACK2);
            // lock spans both acknowledges so no master slips between
            o_bus_lock <= (state_next == CIH_ST_ACK1) ||
                          (state_next == CIH_ST_ACK2);
            o_vector_take <= (state_next == CIH_ST_VECTOR);
        end
    end

    // core restart pulse; caches are not touched here
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_core_reset <= 1'b1;
        end else begin
            o_core_reset <= (state_reg == CIH_ST_RUN) & init_pulse;
        end
    end

    assign o_bist_active = (state_reg == CIH_ST_BIST);
    assign o_running = (state_reg == CIH_ST_RUN);

    // routed nonmaskable and local lines zero and one
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_nmi <= 1'b0;
            o_local_irq_line_zero <= 1'b0;
            o_local_irq_line_one <= 1'b0;
        end else begin
            o_nmi <= irq.nmi_in;
            o_local_irq_line_zero <= irq.local_irq_line_zero;
            o_local_irq_line_one <= irq.local_irq_line_one;
        end
    end

    // capture invalidate in the strobe clock
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            inq_pend_reg <= 1'b0;
            inv_reg <= 1'b0;
        end else begin
            inq_pend_reg <= ~i_external_addr_strobe_n;
            if (!i_external_addr_strobe_n) begin
                inv_reg <= i_inquire_invalidate_in;
            end
        end
    end

    // final line state from the captured invalidate
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_line_update <= 1'b0;
            o_line_state <= CIH_LINE_INVALID;
        end else begin
            o_line_update <= inq_pend_reg & i_inquire_hit;
            if (inq_pend_reg && i_inquire_hit) begin
                o_line_state <= inv_reg ? CIH_LINE_INVALID
                                        : CIH_LINE_SHARED;
            end
        end
    end

    // cacheable cycle with enable becomes burst fill
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_burst_fill <= 1'b0;
            o_xfer_count <= `CIH_SINGLE_XFERS;
        end else if (i_cycle.valid && i_bus_ready) begin
            if (i_cycle.cacheable && !i_cache_enable_in_n) begin
                o_burst_fill <= 1'b1;
                o_xfer_count <= `CIH_BURST_XFERS;
            end else begin
                o_burst_fill <= 1'b0;
                o_xfer_count <= `CIH_SINGLE_XFERS;
            end
        end
    end

    AST_SELFTEST_ENTRY: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (rst_seen_reg && i_soft_init) |=> o_bist_active)
        else $error("self test not entered after init at reset");

    AST_NO_SELFTEST: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (rst_seen_reg && !i_soft_init) |=> o_running)
        else $error("unexpected self test");

    AST_TWO_ACKS: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (o_running && take_irq && !init_pulse) |=>
        o_inta_cycle [*8] ##1 o_vector_take)
        else $error("acknowledge sequence wrong");

    AST_ACK_COUNT: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_reg == CIH_ST_VECTOR) |-> (ack_num_reg == `CIH_ACK_CYCLES))
        else $error("acknowledge count wrong");

    AST_LOCK_WITH_ACK: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        o_inta_cycle |-> o_bus_lock)
        else $error("acknowledge not locked");

    AST_BOUNDARY: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (o_running && !i_instr_done) |=> !o_inta_cycle)
        else $error("interrupt taken mid instruction");

    AST_INIT_RESTART: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (o_running && init_pulse) |=> o_core_reset && o_running)
        else $error("soft init did not restart");

    AST_LINE_STATE: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (!i_external_addr_strobe_n ##1 i_inquire_hit) |=>
        o_line_update && (o_line_state == (
            $past(i_inquire_invalidate_in, 2) ? CIH_LINE_INVALID
                                              : CIH_LINE_SHARED)))
        else $error("inquire line state wrong");

    AST_BURST: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_cycle.valid && i_bus_ready && i_cycle.cacheable &&
         !i_cache_enable_in_n) |=> o_burst_fill &&
        (o_xfer_count == `CIH_BURST_XFERS))
        else $error("burst fill not formed");

    AST_SINGLE: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_cycle.valid && i_bus_ready && i_cache_enable_in_n) |=>
        !o_burst_fill && (o_xfer_count == `CIH_SINGLE_XFERS))
        else $error("uncached cycle length wrong");

    AST_ROUTE_ONE: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        i_pin_irq1 |=> (o_nmi != o_local_irq_line_one))
        else $error("pin one routing wrong");

    AST_ROUTE_ZERO: assert property (
        @(posedge i_ref_clk) disable iff (i_rst)
        (i_pin_irq0 && i_lic_enable) |=> o_local_irq_line_zero)
        else $error("pin zero routing wrong");
endmodule

// ==== logic/cih_defs.svh ====
/*
 constant definitions for the control input handler.
 assumes it is included by the package and the design files by bare name.
*/
`ifndef CIH_DEFS_SVH
`define CIH_DEFS_SVH
`define CIH_ACK_CYCLES 2'h2
`define CIH_ACK_LEN 3'h3
`define CIH_BIST_LEN 8'h10
`define CIH_BURST_XFERS 3'h4
`define CIH_SINGLE_XFERS 3'h1
`define CIH_VEC_W 8
`endif

// ==== logic/cih_pkg.sv ====
/*
 types shared by the control input handler modules.
 assumes cih_defs.svh is on the include path.
*/
`include "cih_defs.svh"
package cih_pkg;
    typedef enum logic [1:0] {
        CIH_LINE_INVALID,
        CIH_LINE_SHARED,
        CIH_LINE_EXCLUSIVE,
        CIH_LINE_MODIFIED
    } cih_line_e;

    typedef enum logic [2:0] {
        CIH_ST_RESET,
        CIH_ST_BIST,
        CIH_ST_RUN,
        CIH_ST_ACK1,
        CIH_ST_ACK2,
        CIH_ST_VECTOR
    } cih_state_e;

    // one bus cycle issued by the core
    typedef struct packed {
        logic valid;
        logic cacheable;
    } cih_cycle_s;

    // pin routing result
    typedef struct packed {
        logic maskable_irq_in;
        logic nmi_in;
        logic local_irq_line_zero;
        logic local_irq_line_one;
    } cih_irq_s;
endpackage

// ==== logic/cih_irq_router.sv ====
/*
 routes the two shared interrupt pins by local controller enable.
 assumes pins are synchronous to i_ref_clk.
*/
`timescale 1ns/10ps
module cih_irq_router
    import cih_pkg::*;
(
    // pins
    input wire logic i_pin_irq0,
    input wire logic i_pin_irq1,
    input wire logic i_lic_enable,
    // routed
    output cih_irq_s o_irq
);
    always_comb begin
        o_irq.maskable_irq_in = i_pin_irq0 & ~i_lic_enable;
        o_irq.local_irq_line_zero = i_pin_irq0 & i_lic_enable;
        o_irq.nmi_in = i_pin_irq1 & ~i_lic_enable;
        o_irq.local_irq_line_one = i_pin_irq1 & i_lic_enable;
    end
endmodule

// ==== test/cih_chipset_model.sv ====
/*
 chipset side model: maskable interrupt source and inquire driver.
 assumes the bench requests events by one-cycle pulses on i_ref_clk.
*/
`timescale 1ns/10ps
module cih_chipset_model (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rst,
    // bench requests
    input wire logic i_raise_irq,
    input wire logic i_drop_irq,
    input wire logic i_inq_req,
    input wire logic i_inq_inv,
    input wire logic i_inq_hit,
    // device side
    input wire logic i_inta_cycle,
    output logic o_pin_irq0,
    output logic o_strobe_n,
    output logic o_inv,
    output logic o_hit
);
    logic hit_pend_reg;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pin_irq0 <= 1'b0;
        end else if (i_raise_irq) begin
            o_pin_irq0 <= 1'b1;
        end else if (i_inta_cycle || i_drop_irq) begin
            o_pin_irq0 <= 1'b0;
        end
    end

    // invalidate valid in strobe clock
    // outside the strobe clock the line toggles so a late sample shows
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_strobe_n <= 1'b1;
            o_inv <= 1'b0;
            hit_pend_reg <= 1'b0;
            o_hit <= 1'b0;
        end else begin
            o_strobe_n <= !i_inq_req;
            o_inv <= i_inq_req ? i_inq_inv : !o_inv;
            hit_pend_reg <= i_inq_req & i_inq_hit;
            o_hit <= hit_pend_reg;
        end
    end
endmodule

// ==== test/tb_top.sv ====
/*
 self-checking bench for the control input handler.
 assumes the chipset model drives pin zero and the inquire pins.
*/
`timescale 1ns/10ps
`include "cih_defs.svh"
module tb_top;
    import cih_pkg::*;
    logic i_ref_clk, i_rst, i_soft_init, i_pin_irq1, i_lic_enable;
    logic i_cache_enable_in_n, i_if_flag, i_instr_done, i_bus_ready;
    logic raise, drop, inq_req, inq_inv, inq_hit;
    logic pin0, strobe_n, inquire_invalidate_in, hit;
    cih_cycle_s i_cycle;
    logic o_core_reset, o_bist_active, o_running, o_inta_cycle;
    logic o_bus_lock, o_vector_take, o_nmi, o_lz, o_lo, o_line_update;
    logic o_burst_fill;
    cih_line_e o_line_state;
    logic [2:0] o_xfer_count;
    int n_mismatch = 0;
    int total_checks = 0;

    cih_top dut_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_soft_init(i_soft_init), .i_pin_irq0(pin0),
        .i_pin_irq1(i_pin_irq1), .i_lic_enable(i_lic_enable),
        .i_inquire_invalidate_in(inquire_invalidate_in), .i_external_addr_strobe_n(strobe_n),
        .i_inquire_hit(hit), .i_cache_enable_in_n(i_cache_enable_in_n),
        .i_if_flag(i_if_flag), .i_instr_done(i_instr_done),
        .i_cycle(i_cycle), .i_bus_ready(i_bus_ready),
        .o_core_reset(o_core_reset), .o_bist_active(o_bist_active),
        .o_running(o_running), .o_inta_cycle(o_inta_cycle),
        .o_bus_lock(o_bus_lock), .o_vector_take(o_vector_take),
        .o_nmi(o_nmi), .o_local_irq_line_zero(o_lz),
        .o_local_irq_line_one(o_lo), .o_line_update(o_line_update),
        .o_line_state(o_line_state), .o_burst_fill(o_burst_fill),
        .o_xfer_count(o_xfer_count));

    cih_chipset_model model_u (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_raise_irq(raise), .i_drop_irq(drop), .i_inq_req(inq_req),
        .i_inq_inv(inq_inv), .i_inq_hit(inq_hit),
        .i_inta_cycle(o_inta_cycle), .o_pin_irq0(pin0),
        .o_strobe_n(strobe_n), .o_inv(inquire_invalidate_in), .o_hit(hit));

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick();
        @(posedge i_ref_clk);
        #1;
    endtask

    // 0 inta, 1 line update, 2 core reset, 3 running
    task automatic wait_hi(input int k, input int lim);
        int n;
        n = 0;
        // look in the current cycle first so its high cycle is counted
        #1;
        while ((k == 0 ? o_inta_cycle : k == 1 ? o_line_update :
                k == 2 ? o_core_reset : o_running) !== 1'b1) begin
            tick();
            n++;
            if (n > lim) begin
                $display("Error at %0t: wait timed out", $time);
                n_mismatch++;
                close_out();
            end
        end
    endtask

    task automatic watch_none(input int lim);
        logic seen;
        seen = 1'b0;
        repeat (lim) begin
            tick();
            if (o_inta_cycle !== 1'b0) seen = 1'b1;
        end
        check({7'h00, seen}, 8'h00);
    endtask

    task automatic pulse_done();
        @(posedge i_ref_clk);
        i_instr_done <= 1'b1;
        @(posedge i_ref_clk);
        i_instr_done <= 1'b0;
    endtask

    task automatic raise_irq();
        @(posedge i_ref_clk);
        raise <= 1'b1;
        @(posedge i_ref_clk);
        raise <= 1'b0;
    endtask

    task automatic reset_dut(input logic init);
        int n;
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        i_soft_init <= init;
        repeat (2) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        tick();
        check({7'h00, o_core_reset}, 8'h00);
        check({7'h00, o_bist_active}, {7'h00, init});
        n = 0;
        while (o_bist_active === 1'b1 && n < 40) begin
            tick();
            n++;
        end
        check(n[7:0], init ? 8'(`CIH_BIST_LEN + 1) : 8'h00);
        check({7'h00, o_running}, 8'h01);
        @(posedge i_ref_clk);
        i_soft_init <= 1'b0;
        $display("test reset done");
    endtask

    task automatic test_pins();
        for (int l = 0; l < 2; l++) begin
            @(posedge i_ref_clk);
            i_lic_enable <= l[0];
            i_pin_irq1 <= 1'b1;
            raise_irq();
            repeat (2) tick();
            check({7'h00, o_lz}, {7'h00, l[0]});
            check({7'h00, o_lo}, {7'h00, l[0]});
            check({7'h00, o_nmi}, {7'h00, !l[0]});
            @(posedge i_ref_clk);
            drop <= 1'b1;
            i_pin_irq1 <= 1'b0;
            i_lic_enable <= 1'b0;
            @(posedge i_ref_clk);
            drop <= 1'b0;
        end
        $display("test pins done");
    endtask

    task automatic test_irq();
        int n;
        raise_irq();
        pulse_done();
        watch_none(12);
        @(posedge i_ref_clk);
        i_if_flag <= 1'b1;
        watch_none(12);
        pulse_done();
        wait_hi(0, 4);
        n = 0;
        while (o_inta_cycle === 1'b1 && n < 20) begin
            check({7'h00, o_bus_lock}, 8'h01);
            n++;
            tick();
        end
        check(n[7:0], 8'(`CIH_ACK_CYCLES * (`CIH_ACK_LEN + 1)));
        check({7'h00, o_vector_take}, 8'h01);
        tick();
        check({7'h00, o_vector_take}, 8'h00);
        @(posedge i_ref_clk);
        i_lic_enable <= 1'b1;
        raise_irq();
        pulse_done();
        watch_none(12);
        @(posedge i_ref_clk);
        drop <= 1'b1;
        i_lic_enable <= 1'b0;
        i_if_flag <= 1'b0;
        @(posedge i_ref_clk);
        drop <= 1'b0;
        $display("test irq done");
    endtask

    task automatic test_inquire();
        for (int v = 1; v >= 0; v--) begin
            @(posedge i_ref_clk);
            inq_req <= 1'b1;
            inq_inv <= v[0];
            inq_hit <= 1'b1;
            @(posedge i_ref_clk);
            inq_req <= 1'b0;
            wait_hi(1, 6);
            check(8'(o_line_state),
                8'(v[0] ? CIH_LINE_INVALID : CIH_LINE_SHARED));
        end
        $display("test inquire done");
    endtask

    task automatic test_cycles();
        logic c, kn;
        for (int k = 0; k < 3; k++) begin
            c = (k != 2);
            kn = (k == 0);
            @(posedge i_ref_clk);
            i_cycle <= '{valid: 1'b1, cacheable: c};
            i_cache_enable_in_n <= kn;
            i_bus_ready <= 1'b1;
            @(posedge i_ref_clk);
            i_cycle <= '0;
            i_bus_ready <= 1'b0;
            tick();
            check({7'h00, o_burst_fill}, {7'h00, c & !kn});
            check({5'h00, o_xfer_count}, (c & !kn) ? 8'(`CIH_BURST_XFERS)
                : 8'(`CIH_SINGLE_XFERS));
        end
        $display("test cycles done");
    endtask

    task automatic test_soft_init();
        @(posedge i_ref_clk);
        i_soft_init <= 1'b1;
        wait_hi(2, 4);
        tick();
        check({7'h00, o_core_reset}, 8'h00);
        @(posedge i_ref_clk);
        i_soft_init <= 1'b0;
        wait_hi(3, 30);
        check(8'(o_line_state), 8'(CIH_LINE_SHARED));
        $display("test soft init done");
    endtask

    initial begin
        i_rst = 1'b1;
        i_soft_init = 1'b0;
        i_pin_irq1 = 1'b0;
        i_lic_enable = 1'b0;
        i_cache_enable_in_n = 1'b1;
        i_if_flag = 1'b0;
        i_instr_done = 1'b0;
        i_bus_ready = 1'b0;
        i_cycle = '0;
        raise = 1'b0;
        drop = 1'b0;
        inq_req = 1'b0;
        inq_inv = 1'b0;
        inq_hit = 1'b0;
        reset_dut(1'b1);
        reset_dut(1'b0);
        test_pins();
        test_irq();
        test_inquire();
        test_cycles();
        test_soft_init();
        close_out();
    end
endmodule
